// file: hw/geared_pulse_counter.sv
`timescale 1ns/10ps
// Operation
// RQ1: every input pulse increments 32-bit raw total
// RQ2: scaled count is raw times multiplier over divisor
// RQ3: scaled count readable apart from raw total
// RQ4: gear values 1..65535, both default 1
// RQ5: reached output once scaled meets target
// RQ6: ceiling stops or restarts the count
// RQ7: reset terminal active clears the counter
// RQ8: method 0 stops, 1 clears and resumes
// RQ9: reached requests action from action digit
// RQ10: retain digit keeps count over power loss
// RQ11: counter reset clears both counts and reached
module geared_pulse_counter
  import counter_pkg::*;
(
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // register port
  input  counter_pkg::bus_req_type       bus_req,
  output logic [31:0]                    rdata_q,
  // digital input terminals
  input  wire logic                      count_pin,
  input  wire logic                      reset_pin,
  input  wire logic                      power_fail_pin,
  // digital outputs
  output logic                           target_reached_q,
  output logic [1:0]                     action_req_q,
  output logic                           irq_q
);
  import counter_pkg::*;

  // register write hit
  function automatic logic wr_hit(input bus_req_type r, input logic [7:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  // filtered pins
  logic [PIN_N-1:0] pin_level;        // steady levels
  logic [PIN_N-1:0] pin_rise;         // rising pulses
  // software registers
  logic [31:0]      target_q;         // target count
  logic [31:0]      ceil_q;           // count ceiling
  logic [15:0]      mul_q;            // gear multiplier
  logic [15:0]      div_q;            // gear divisor
  ctrl_type         ctrl_q;           // behaviour control
  logic [EV_W-1:0]  stat_q;           // sticky events
  logic [EV_W-1:0]  stat_d;           // next sticky events
  logic [EV_W-1:0]  ien_q;            // event enables
  // counter state
  logic [31:0]      raw_q;            // raw pulse total
  logic [31:0]      scaled_q;         // scaled count
  logic             stop_q;           // halted at ceiling
  logic             dirty_q;          // scaled needs redo
  // divider state
  div_state_type    state_q;          // divider phase
  logic [47:0]      dq_q;             // dividend, then quotient
  logic [16:0]      rem_q;            // partial remainder
  logic [5:0]       cnt_q;            // step counter
  // combinational terms
  logic [47:0]      prod;             // raw times multiplier
  logic [16:0]      rem_sh;           // shifted remainder
  logic             rem_ge;           // subtract fits
  logic [31:0]      quot_cap;         // saturated quotient
  logic             at_ceil;          // result reaches ceiling
  logic             clr_all;          // counter reset
  logic             wrap_now;         // wrap at ceiling
  logic             stop_now;         // halt at ceiling
  logic             count_en;         // take one pulse
  logic             start;            // begin a division
  logic [EV_W-1:0]  ev_set;           // event pulses
  logic [31:0]      rd_mux;           // read value
  // pin synchronisers
  pin_filter u_pins (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   ({power_fail_pin, reset_pin, count_pin}),
    .level_q  (pin_level),
    .rise_q   (pin_rise)
  );
  // counter control terms
  always_comb
  begin
    // reset terminal, or power loss without retain
    clr_all  = pin_level[PIN_RESET]                         // RQ7
             || (pin_rise[PIN_POWER] && !ctrl_q.retain);    // RQ10
    prod     = raw_q * mul_q;                               // RQ2
    quot_cap = (dq_q[47:32] != ZERO_G) ? CEIL_RST : dq_q[31:0];
    at_ceil  = (state_q == ST_DONE) && (quot_cap >= ceil_q);
    wrap_now = at_ceil && ctrl_q.wrap && !clr_all;          // RQ8
    stop_now = at_ceil && !ctrl_q.wrap && !clr_all;         // RQ8
    count_en = pin_rise[PIN_COUNT] && !stop_q && !clr_all && !wrap_now;
    start    = (state_q == ST_IDLE) && dirty_q && !clr_all;
    rem_sh   = {rem_q[15:0], dq_q[47]};
    rem_ge   = rem_sh >= {1'b0, div_q};
  end
  // raw pulse total; power-on and counter clear share a branch
  always_ff @(posedge core_clk)
  begin
    if (rst || clr_all || wrap_now)
    begin
      raw_q <= ZERO_W;                                      // RQ11
    end
    else if (count_en)
    begin
      raw_q <= raw_q + 32'h00000001;                        // RQ1
    end
  end
  // recompute flag: new pulse or gear change sets, start clears
  always_ff @(posedge core_clk)
  begin
    if (rst || clr_all || wrap_now)
    begin
      dirty_q <= 1'b0;
    end
    else if (count_en || wr_hit(bus_req, OFS_MUL) || wr_hit(bus_req, OFS_DIV))
    begin
      dirty_q <= 1'b1;
    end
    else if (start)
    begin
      dirty_q <= 1'b0;
    end
  end
  // restoring divider, one quotient bit a cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      dq_q    <= 48'h000000000000;
      rem_q   <= 17'h00000;
      cnt_q   <= 6'h00;
    end
    else if (clr_all)
    begin
      state_q <= ST_IDLE;                                   // abort on reset
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            dq_q    <= prod;                                // RQ2
            rem_q   <= 17'h00000;
            cnt_q   <= 6'h00;
            state_q <= ST_DIV;
          end
        end
        ST_DIV:
        begin
          rem_q <= rem_ge ? (rem_sh - {1'b0, div_q}) : rem_sh;
          dq_q  <= {dq_q[46:0], rem_ge};
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == DIV_LAST)
          begin
            state_q <= ST_DONE;
          end
        end
        default:                                            // done or stray code
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
  // scaled count: result lands once division ends
  always_ff @(posedge core_clk)
  begin
    if (rst || clr_all || wrap_now)
    begin
      scaled_q <= ZERO_W;                                   // RQ11 RQ8
    end
    else if (state_q == ST_DONE)
    begin
      scaled_q <= at_ceil ? ceil_q : quot_cap;              // RQ2 RQ6
    end
  end
  // halt latch for stop method
  always_ff @(posedge core_clk)
  begin
    if (rst || clr_all)
    begin
      stop_q <= 1'b0;
    end
    else if (stop_now)
    begin
      stop_q <= 1'b1;                                       // RQ6
    end
  end
  // reached flag follows scaled against target
  always_ff @(posedge core_clk)
  begin
    if (rst || clr_all)
    begin
      target_reached_q <= 1'b0;                             // RQ11
    end
    else
    begin
      target_reached_q <= scaled_q >= target_q;             // RQ5
    end
  end
  // drive action request while reached
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      action_req_q <= ACT_RUN;
    end
    else
    begin
      action_req_q <= target_reached_q ? ctrl_q.action : ACT_RUN; // RQ9
    end
  end
  // settings; zero writes to target, ceiling and gears are refused
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      target_q <= TARGET_RST;
      ceil_q   <= CEIL_RST;
      mul_q    <= GEAR_RST;
      div_q    <= GEAR_RST;
      ctrl_q   <= CTRL_RST;
      ien_q    <= '0;
    end
    else
    begin
      if (wr_hit(bus_req, OFS_TARGET) && bus_req.wdata != ZERO_W)
      begin
        target_q <= bus_req.wdata;                          // RQ5
      end
      if (wr_hit(bus_req, OFS_CEIL) && bus_req.wdata != ZERO_W)
      begin
        ceil_q <= bus_req.wdata;                            // RQ6
      end
      if (wr_hit(bus_req, OFS_MUL) && bus_req.wdata[15:0] != ZERO_G)
      begin
        mul_q <= bus_req.wdata[15:0];                       // RQ4
      end
      if (wr_hit(bus_req, OFS_DIV) && bus_req.wdata[15:0] != ZERO_G)
      begin
        div_q <= bus_req.wdata[15:0];                       // RQ4
      end
      if (wr_hit(bus_req, OFS_CTRL))
      begin
        ctrl_q.wrap   <= bus_req.wdata[CTRL_WRAP_BIT];
        ctrl_q.action <= bus_req.wdata[CTRL_ACT_LSB +: 2];
        ctrl_q.retain <= bus_req.wdata[CTRL_RETAIN_BIT];
      end
      if (wr_hit(bus_req, OFS_IEN))
      begin
        ien_q <= bus_req.wdata[EV_W-1:0];
      end
    end
  end
  // events: set wins over clear
  always_comb
  begin
    ev_set            = '0;
    ev_set[EV_TARGET] = (scaled_q >= target_q) && !target_reached_q && !clr_all;
    ev_set[EV_CEIL]   = at_ceil && !clr_all;
    stat_d            = stat_q;
    if (wr_hit(bus_req, OFS_CLR))
    begin
      stat_d = stat_q & ~bus_req.wdata[EV_W-1:0];
    end
    stat_d = stat_d | ev_set;
  end
  // sticky status and interrupt level
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      stat_q <= '0;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      irq_q  <= |(stat_d & ien_q);
    end
  end
  // read decode; unmapped reads zero
  always_comb
  begin
    case (bus_req.addr)
      OFS_RAW:    rd_mux = raw_q;                           // RQ1
      OFS_SCALED: rd_mux = scaled_q;                        // RQ3
      OFS_TARGET: rd_mux = target_q;
      OFS_CEIL:   rd_mux = ceil_q;
      OFS_MUL:    rd_mux = {ZERO_G, mul_q};
      OFS_DIV:    rd_mux = {ZERO_G, div_q};
      OFS_CTRL:
      begin
        rd_mux                      = ZERO_W;
        rd_mux[CTRL_WRAP_BIT]       = ctrl_q.wrap;
        rd_mux[CTRL_ACT_LSB +: 2]   = ctrl_q.action;
        rd_mux[CTRL_RETAIN_BIT]     = ctrl_q.retain;
      end
      OFS_STAT:   rd_mux = {30'h00000000, stat_q};
      OFS_IEN:    rd_mux = {30'h00000000, ien_q};
      default:    rd_mux = ZERO_W;
    endcase
  end
  // read data stands one cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rdata_q <= ZERO_W;
    end
    else
    begin
      rdata_q <= bus_req.rd ? rd_mux : ZERO_W;
    end
  end
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // division launch and finish
  sequence s_launch;
    (state_q == ST_IDLE) && dirty_q && !clr_all;
  endsequence
  sequence s_finish;
    (state_q == ST_DONE) && !clr_all && !at_ceil;
  endsequence
  a_raw_counts: assert property (count_en |=> raw_q == $past(raw_q) + 32'h00000001) // RQ1
    else $error("raw total missed a pulse");
  // a counter clear aborts the division, so it also drops the attempt
  a_div_launch: assert property (disable iff (rst || clr_all) // RQ2
    s_launch |-> ##49 state_q == ST_DONE)
    else $error("division did not end on time");
  a_scaled_lands: assert property (s_finish |=> scaled_q == $past(quot_cap)) // RQ2
    else $error("scaled count not the quotient");
  a_scaled_ro: assert property (wr_hit(bus_req, OFS_SCALED) && state_q != ST_DONE // RQ3
    && !clr_all && !wrap_now |=> $stable(scaled_q))
    else $error("scaled count took a write");
  a_gear_nonzero: assert property (mul_q != ZERO_G && div_q != ZERO_G) // RQ4
    else $error("gear value zero");
  a_reached_cause: assert property ($rose(target_reached_q) // RQ5
    |-> $past(scaled_q) >= $past(target_q))
    else $error("reached without target");
  a_ceiling_halt: assert property (stop_now |=> stop_q // RQ6 RQ8
    ##1 (raw_q == $past(raw_q) || $past(clr_all)))
    else $error("count moved after halt");
  a_wrap_clear: assert property (wrap_now |=> raw_q == ZERO_W && scaled_q == ZERO_W) // RQ8
    else $error("wrap did not clear");
  a_reset_clears: assert property (pin_level[PIN_RESET] |=> raw_q == ZERO_W // RQ7 RQ11
    && scaled_q == ZERO_W && !target_reached_q)
    else $error("reset terminal did not clear");
  a_power_keep: assert property (pin_rise[PIN_POWER] && ctrl_q.retain // RQ10
    && !pin_level[PIN_RESET] && !count_en && !wrap_now |=> raw_q == $past(raw_q))
    else $error("retained count lost");
  a_action_code: assert property (target_reached_q |=> action_req_q == $past(ctrl_q.action)) // RQ9
    else $error("wrong action request");
endmodule

// file: shared/counter_pkg.sv
package counter_pkg;
  // bus and data widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned GEAR_W = 16;
  localparam int unsigned PROD_W = 48;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_RAW    = 8'h00;
  localparam logic [7:0] OFS_SCALED = 8'h04;
  localparam logic [7:0] OFS_TARGET = 8'h08;
  localparam logic [7:0] OFS_CEIL   = 8'h0c;
  localparam logic [7:0] OFS_MUL    = 8'h10;
  localparam logic [7:0] OFS_DIV    = 8'h14;
  localparam logic [7:0] OFS_CTRL   = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1c;
  localparam logic [7:0] OFS_CLR    = 8'h20;
  localparam logic [7:0] OFS_IEN    = 8'h24;
  // reset values
  localparam logic [31:0] TARGET_RST = 32'h000003e8;
  localparam logic [31:0] CEIL_RST   = 32'hffffffff;
  localparam logic [15:0] GEAR_RST   = 16'h0001;
  localparam logic [31:0] ZERO_W     = 32'h00000000;
  localparam logic [15:0] ZERO_G     = 16'h0000;
  // control field positions
  localparam int unsigned CTRL_WRAP_BIT   = 0;
  localparam int unsigned CTRL_ACT_LSB    = 4;
  localparam int unsigned CTRL_RETAIN_BIT = 8;
  // event bits
  localparam int unsigned EV_TARGET = 0;
  localparam int unsigned EV_CEIL   = 1;
  localparam int unsigned EV_W      = 2;
  // pin indices
  localparam int unsigned PIN_COUNT = 0;
  localparam int unsigned PIN_RESET = 1;
  localparam int unsigned PIN_POWER = 2;
  localparam int unsigned PIN_N     = 3;
  // divider step count
  localparam logic [5:0] DIV_LAST = 6'h2f;
  // action codes
  localparam logic [1:0] ACT_RUN = 2'h0;
  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;
  // counter control fields
  typedef struct packed {
    logic       retain;
    logic [1:0] action;
    logic       wrap;
  } ctrl_type;
  localparam ctrl_type CTRL_RST = '{retain: 1'b0, action: 2'h0, wrap: 1'b1};
  // divider states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_DONE = 2'b10
  } div_state_type;
endpackage

// file: hw/pin_filter.sv
`timescale 1ns/10ps
module pin_filter
  import counter_pkg::*;
(
  // clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst,
  // raw pins
  input  wire logic [counter_pkg::PIN_N-1:0]       pin_in,
  // filtered level and rising pulse
  output logic      [counter_pkg::PIN_N-1:0]       level_q,
  output logic      [counter_pkg::PIN_N-1:0]       rise_q
);
  import counter_pkg::*;
  // three stage chain per pin
  logic [PIN_N-1:0] s1_q;
  logic [PIN_N-1:0] s2_q;
  logic [PIN_N-1:0] s3_q;
  genvar g;
  generate
    for (g = 0; g < PIN_N; g++)
    begin : g_pin
      // chain: first stage feeds only the second
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
        end
        else
        begin
          s1_q[g] <= pin_in[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
        end
      end
      // level moves once stages two and three agree
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          level_q[g] <= 1'b0;
          rise_q[g]  <= 1'b0;
        end
        else
        begin
          if (s2_q[g] == s3_q[g])
          begin
            level_q[g] <= s3_q[g];
          end
          rise_q[g] <= (s2_q[g] == s3_q[g]) && s3_q[g] && !level_q[g];
        end
      end
    end
  endgenerate
endmodule

// file: tb/pulse_source.sv
`timescale 1ns/10ps
// model of the pulse source wired to the counter input terminal
module pulse_source #(
  parameter int unsigned HIGH_CYC = 4,  // pin high time per pulse
  parameter int unsigned LOW_CYC  = 60  // pin low time, covers one division
)
(
  // clock
  input  wire logic       core_clk,
  // burst request from the bench
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  // terminal and burst status
  output logic            count_pin,
  output logic            busy
);
  initial
  begin
    count_pin = 1'b0;
    busy      = 1'b0;
  end
  // one burst per start; spacing keeps every level wide enough to be seen
  always
  begin
    @(posedge core_clk);
    if (start)
    begin
      busy <= 1'b1;
      repeat (pulses)
      begin
        count_pin <= 1'b1;
        repeat (HIGH_CYC) @(posedge core_clk);
        count_pin <= 1'b0;
        repeat (LOW_CYC) @(posedge core_clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// file: tb/geared_pulse_counter_test.sv
`timescale 1ns/10ps
// self-checking bench for the geared pulse counter
module geared_pulse_counter_test;
  import counter_pkg::*;
  logic                    core_clk;       // 100 MHz clock
  logic                    rst;            // synchronous reset
  counter_pkg::bus_req_type bus_req;       // register request
  logic [31:0]             rdata_q;        // read data
  logic                    count_pin;      // pulse terminal
  logic                    reset_pin;      // counter reset terminal
  logic                    power_fail_pin; // power loss terminal
  logic                    target_reached_q;
  logic [1:0]              action_req_q;
  logic                    irq_q;
  logic                    start;          // burst request
  logic [7:0]              pulses;         // burst length
  logic                    busy;           // burst running
  int                      fails;
  int                      comparisons;
  int                      cycles;

  geared_pulse_counter i_geared_pulse_counter (
    .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rdata_q(rdata_q),
    .count_pin(count_pin), .reset_pin(reset_pin), .power_fail_pin(power_fail_pin),
    .target_reached_q(target_reached_q), .action_req_q(action_req_q), .irq_q(irq_q));

  pulse_source i_pulse_source (
    .core_clk(core_clk), .start(start), .pulses(pulses),
    .count_pin(count_pin), .busy(busy));

  // clock generator
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // compare one value and count it
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // single-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  // single-cycle read strobe, data sampled in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata_q;
  endtask

  // read a register and compare it
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(name, d, exp);
  endtask

  // send a burst and wait for it under a bound
  task automatic burst(input logic [7:0] n);
    int k;
    @(posedge core_clk);
    start  <= 1'b1;
    pulses <= n;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
    for (k = 0; k < 2000 && busy === 1'b1; k++) @(posedge core_clk);
    // a pulse landing mid-division waits for that one, then its own
    repeat (60) @(posedge core_clk);
    #1;
    check("burst_done", busy, 32'h0);
  endtask

  // drive a terminal high for a while, then low again
  task automatic pin_pulse(input bit which);
    @(posedge core_clk);
    if (which) power_fail_pin <= 1'b1;
    else reset_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    reset_pin      <= 1'b0;
    power_fail_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
  endtask

  // register defaults, an unmapped read and refused writes
  task automatic t_defaults();
    rd_chk("raw", OFS_RAW, 32'h00000000);
    rd_chk("scaled", OFS_SCALED, 32'h00000000);
    rd_chk("target", OFS_TARGET, 32'h000003e8);
    rd_chk("ceiling", OFS_CEIL, 32'hffffffff);
    rd_chk("mul", OFS_MUL, 32'h00000001);
    rd_chk("div", OFS_DIV, 32'h00000001);
    rd_chk("ctrl", OFS_CTRL, 32'h00000001);
    rd_chk("unmapped", 8'h30, 32'h00000000);
    wr(OFS_MUL, 32'h00000000);
    wr(OFS_RAW, 32'h00000055);
    wr(OFS_SCALED, 32'h00000077);
    rd_chk("mul_zero", OFS_MUL, 32'h00000001);
    rd_chk("raw_ro", OFS_RAW, 32'h00000000);
    rd_chk("scaled_ro", OFS_SCALED, 32'h00000000);
  endtask

  // gear 3/2, reached exactly at the target, irq masking and clearing
  task automatic t_gear_reach();
    wr(OFS_MUL, 32'h00000003);
    wr(OFS_DIV, 32'h00000002);
    wr(OFS_TARGET, 32'h00000006);
    burst(8'h03);
    rd_chk("raw3", OFS_RAW, 32'h00000003);
    rd_chk("scaled3", OFS_SCALED, 32'h00000004);
    check("reached_lo", target_reached_q, 32'h0);
    burst(8'h01);
    rd_chk("scaled4", OFS_SCALED, 32'h00000006);
    check("reached_hi", target_reached_q, 32'h1);
    check("irq_masked", irq_q, 32'h0);
    wr(OFS_IEN, 32'h00000001);
    repeat (3) @(posedge core_clk);
    #1 check("irq_on", irq_q, 32'h1);
    pin_pulse(1'b0);
    check("reached_clr", target_reached_q, 32'h0);
    rd_chk("raw_clr", OFS_RAW, 32'h00000000);
    rd_chk("scaled_clr", OFS_SCALED, 32'h00000000);
    wr(OFS_CLR, 32'h00000003);
    rd_chk("status_clr", OFS_STAT, 32'h00000000);
    check("irq_off", irq_q, 32'h0);
  endtask

  // every action code is passed on while reached
  task automatic t_actions();
    logic [31:0] c;
    wr(OFS_MUL, 32'h00000001);
    wr(OFS_DIV, 32'h00000001);
    wr(OFS_TARGET, 32'h00000001);
    burst(8'h01);
    for (int a = 0; a < 4; a++)
    begin
      c = 32'h00000001 | (32'(a) << CTRL_ACT_LSB);
      wr(OFS_CTRL, c);
      repeat (3) @(posedge core_clk);
      #1 check("action", action_req_q, 32'(a));
    end
    wr(OFS_CTRL, 32'h00000001);
    pin_pulse(1'b0);
    check("action_idle", action_req_q, 32'h0);
  endtask

  // ceiling with stop and with wrap
  task automatic t_ceiling();
    wr(OFS_TARGET, 32'h00000064);
    wr(OFS_CEIL, 32'h00000003);
    wr(OFS_CTRL, 32'h00000000);
    burst(8'h05);
    rd_chk("stop", OFS_SCALED, 32'h00000003);
    rd_chk("ceil_event", OFS_STAT, 32'h00000003);
    pin_pulse(1'b0);
    wr(OFS_CTRL, 32'h00000001);
    burst(8'h05);
    rd_chk("wrap_raw", OFS_RAW, 32'h00000002);
    rd_chk("wrap", OFS_SCALED, 32'h00000002);
    pin_pulse(1'b0);
    wr(OFS_CEIL, 32'hffffffff);
  endtask

  // pulses are refused while the reset terminal stands high
  task automatic t_reset_hold();
    @(posedge core_clk);
    reset_pin <= 1'b1;
    burst(8'h02);
    @(posedge core_clk);
    reset_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd_chk("held", OFS_RAW, 32'h00000000);
  endtask

  // power loss with and without retention
  task automatic t_power();
    burst(8'h02);
    pin_pulse(1'b1);
    rd_chk("lost", OFS_RAW, 32'h00000000);
    wr(OFS_CTRL, 32'h00000101);
    burst(8'h02);
    pin_pulse(1'b1);
    rd_chk("kept", OFS_RAW, 32'h00000002);
  endtask

  // closing report
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      print_verdict();
    end
  end

  // main sequence
  initial
  begin
    fails          = 0;
    comparisons    = 0;
    cycles         = 0;
    rst            = 1'b1;
    bus_req        = '0;
    reset_pin      = 1'b0;
    power_fail_pin = 1'b0;
    start          = 1'b0;
    pulses         = 8'h00;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_defaults();
    t_gear_reach();
    t_actions();
    t_ceiling();
    t_reset_hold();
    t_power();
    print_verdict();
  end
endmodule
